/* File: dv/cdle_lamp_panel.sv */
`timescale 1ns/10ps
// Passive lamp model. Lit pulses are grouped into trains that end after a
// long dark spell; each train keeps its count and a width kind (1 fast,
// 2 slow, 3 mixed) so a blink code can be read back.
module cdle_lamp_panel #(
   parameter int FAST_HALF = 2,
   parameter int SLOW_HALF = 4
) (
   // Clock and clear
   input wire logic clk_sys,
   input wire logic clear,
   // Lamp drive
   input wire logic lamp
);
   int trainCnt[$];
   int trainKind[$];
   int cnt;
   int kind;
   int litLen;
   int darkLen;
   int lastLit;

   always @(posedge clk_sys) begin
      if (clear) begin
         trainCnt.delete();
         trainKind.delete();
         cnt = 0;
         kind = 0;
         litLen = 0;
         darkLen = 0;
         lastLit = 0;
      end else if (lamp === 1'b1) begin
         litLen++;
         darkLen = 0;
      end else begin
         if (litLen > 0) begin
            cnt++;
            lastLit = litLen;
            kind |= (litLen == FAST_HALF) ? 1 : (litLen == SLOW_HALF) ? 2 : 3;
            litLen = 0;
         end
         darkLen++;
         // Dark inside a slow train is one half period, so two more
         // cycles of darkness safely mark the end of a train.
         if (darkLen == SLOW_HALF + 2 && cnt > 0) begin
            trainCnt.push_back(cnt);
            trainKind.push_back(kind);
            cnt = 0;
            kind = 0;
         end
      end
   end
endmodule

/* File: dv/coupler_diag_led_blink_encoder_bench.sv */
`timescale 1ns/10ps
module coupler_diag_led_blink_encoder_bench;
   localparam int FH = 2;
   localparam int SH = 4;
   localparam int FC = 8;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic clear = 1'b1;
   logic busRunning = 1'b1, busError = 1'b0, busBreak = 1'b0;
   logic bootIpSwitchBad = 1'b0, rxActivity = 1'b0, addrPending = 1'b0;
   logic arpAddressed = 1'b1, switchInvalid = 1'b0;
   logic wdActive = 1'b0, wdFault = 1'b0;
   logic [7:0] errCode = 8'h00, errArg = 8'h00, breakPos = 8'h00;
   logic busOkLamp, busErrLamp, runLamp, comLamp, ethErrLamp, watchdog_lamp;
   int n_fail = 0;
   int checks = 0;

   always #5 clk_sys = ~clk_sys;

   cdle_led_encoder #(.FAST_HALF(FH), .SLOW_HALF(SH), .GAP(10),
      .FAST_COUNT(FC)) cdle_led_encoder_i (.clk_sys(clk_sys), .rst(rst),
      .busRunning(busRunning), .busError(busError), .errCode(errCode),
      .errArg(errArg), .busBreak(busBreak), .breakPos(breakPos),
      .bootIpSwitchBad(bootIpSwitchBad), .rxActivity(rxActivity),
      .addrPending(addrPending), .arpAddressed(arpAddressed),
      .switchInvalid(switchInvalid), .wdActive(wdActive), .wdFault(wdFault),
      .busOkLamp(busOkLamp), .busErrLamp(busErrLamp), .runLamp(runLamp),
      .comLamp(comLamp), .ethErrLamp(ethErrLamp),
      .watchdog_lamp(watchdog_lamp));
   cdle_lamp_panel #(.FAST_HALF(FH), .SLOW_HALF(SH)) errPanel
      (.clk_sys(clk_sys), .clear(clear), .lamp(busErrLamp));
   cdle_lamp_panel #(.FAST_HALF(FH), .SLOW_HALF(SH)) comPanel
      (.clk_sys(clk_sys), .clear(clear), .lamp(comLamp));
   cdle_lamp_panel #(.FAST_HALF(FH), .SLOW_HALF(SH)) ethPanel
      (.clk_sys(clk_sys), .clear(clear), .lamp(ethErrLamp));

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check_bit(input logic act, input logic exp, string msg);
      checks++;
      if (act !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask

   task automatic check_num(input int act, input int exp, string msg);
      checks++;
      if (act != exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %0d", $time, msg, act);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // Waits, bounded, until the red lamp has shown n complete trains.
   task automatic wait_trains(input int n);
      int i;
      for (i = 0; i < 3000 && errPanel.trainCnt.size() < n; i++)
         cycles(1);
      if (errPanel.trainCnt.size() < n) begin
         n_fail++;
         $display("wrong value at %0t: blink trains missing", $time);
         complete_run();
      end
   endtask

   // Reads one report starting at train k and returns the next index.
   task automatic check_report(inout int k, input int code, input int arg);
      wait_trains(k + 4);
      check_num(errPanel.trainCnt[k], FC, "start burst count");
      check_num(errPanel.trainKind[k], 1, "start burst rate");
      check_num(errPanel.trainCnt[k+1], code, "code count");
      check_num(errPanel.trainKind[k+1], 2, "code rate");
      k += 2;
      if (arg > 0) begin
         check_num(errPanel.trainCnt[k], arg, "argument count");
         check_num(errPanel.trainKind[k], 2, "argument rate");
         k++;
      end
      check_num(errPanel.trainCnt[k], FC, "repeat burst");
   endtask

   task automatic start_fault;
      clear = 1'b1;
      cycles(1);
      clear = 1'b0;
   endtask

   task automatic end_fault;
      {busError, busBreak, bootIpSwitchBad} = 3'b000;
      cycles(400);
      check_bit(busErrLamp, 1'b0, "red lamp idle");
      check_bit(busOkLamp, 1'b1, "green lamp back");
   endtask

   task automatic t_arp;
      cycles(100);
      check_num(ethPanel.trainCnt.size(), 1, "arp trains");
      check_num(ethPanel.trainCnt[0], 5, "arp pulses");
      check_num(ethPanel.trainKind[0], 1, "arp rate");
      check_bit(ethErrLamp, 1'b0, "error lamp off");
      $display("test arp done");
   endtask

   task automatic t_static;
      check_bit(busOkLamp, 1'b1, "green lamp");
      check_bit(runLamp, 1'b1, "run lamp");
      rxActivity = 1'b1;
      switchInvalid = 1'b1;
      wdActive = 1'b1;
      cycles(2);
      check_bit(comLamp, 1'b1, "com on");
      check_bit(ethErrLamp, 1'b1, "switch error");
      check_bit(watchdog_lamp, 1'b1, "watchdog on");
      rxActivity = 1'b0;
      switchInvalid = 1'b0;
      wdFault = 1'b1;
      cycles(2);
      check_bit(comLamp, 1'b0, "com off");
      check_bit(ethErrLamp, 1'b0, "no error");
      check_bit(watchdog_lamp, 1'b0, "watchdog fault");
      wdFault = 1'b0;
      cycles(2);
      check_bit(watchdog_lamp, 1'b1, "watchdog restart");
      $display("test static lamps done");
   endtask

   task automatic t_com_slow;
      addrPending = 1'b1;
      cycles(60);
      check_num(comPanel.lastLit, SH, "slow com flash");
      addrPending = 1'b0;
      cycles(20);
      check_bit(comLamp, 1'b0, "com idle");
      $display("test address wait done");
   endtask

   task automatic t_boot_ip;
      int k = 0;
      start_fault();
      bootIpSwitchBad = 1'b1;
      busBreak = 1'b1;
      breakPos = 8'h02;
      cycles(2);
      check_bit(busOkLamp, 1'b0, "green off in fault");
      check_report(k, 6, 4);
      end_fault();
      $display("test boot ip switch done");
   endtask

   task automatic t_breaks;
      int k = 0;
      start_fault();
      busBreak = 1'b1;
      breakPos = 8'h01;
      check_report(k, 4, 1);
      end_fault();
      k = 0;
      start_fault();
      busBreak = 1'b1;
      breakPos = 8'h00;
      check_report(k, 4, 0);
      end_fault();
      $display("test bus breaks done");
   endtask

   task automatic t_relatch;
      int k = 0;
      start_fault();
      busError = 1'b1;
      errCode = 8'h02;
      errArg = 8'h03;
      cycles(20);
      errCode = 8'h05;
      errArg = 8'h01;
      check_report(k, 2, 3);
      check_report(k, 5, 1);
      check_bit(runLamp, 1'b1, "run lamp in fault");
      end_fault();
      $display("test relatch done");
   endtask

   initial begin
      cycles(1);
      clear = 1'b0;
      cycles(15);
      rst = 1'b0;
      t_arp();
      t_static();
      t_com_slow();
      t_boot_ip();
      t_breaks();
      t_relatch();
      complete_run();
   end
endmodule

/* File: hdl/cdle_consts.svh */
`ifndef CDLE_CONSTS_SVH
`define CDLE_CONSTS_SVH

// Blink timing in nanoseconds; cycle counts derive from the 10 ns clock.
`define CDLE_CLK_NS        10
`define CDLE_FAST_HALF_NS  50000000
`define CDLE_SLOW_HALF_NS  250000000
`define CDLE_GAP_NS        1000000000
`define CDLE_FAST_HALF_CYC (`CDLE_FAST_HALF_NS / `CDLE_CLK_NS)
`define CDLE_SLOW_HALF_CYC (`CDLE_SLOW_HALF_NS / `CDLE_CLK_NS)
`define CDLE_GAP_CYC       (`CDLE_GAP_NS / `CDLE_CLK_NS)
`define CDLE_FAST_PULSES   8
`define CDLE_ARP_PULSES    5
`define CDLE_CODE_BREAK    8'h04
`define CDLE_CODE_COUPLER  8'h06
`define CDLE_ARG_BOOTIP    8'h04

`endif

/* File: hdl/cdle_led_encoder.sv */
`timescale 1ns/10ps
`include "cdle_consts.svh"
// Contract
// - Green bus lamp lit while the I/O bus runs with no fault.
// - Bus errors shown only by red lamp, one fast and one slow rate.
// - Report order: fast burst, slow train of code, slow train of argument.
// - Break after terminal n reports code 4 with argument n.
// - Invalid switch setting for boot IP reports code 6 argument 4.
// - Communication lamp on while data received, off otherwise.
// - Communication lamp flashes slowly while awaiting a DHCP/BootP address.
// - ARP addressing flashes error lamp rapidly five times, only at power-on.
// - Error lamp shows invalid switch settings, off without error.
// - Watchdog lamp on while watchdog active and error free, else off.
// - Run lamp on while the I/O bus runs.
// - Break directly after the coupler reports code 4 argument 0.
module cdle_led_encoder
   import cdle_pkg::*;
#(
   parameter int FAST_HALF  = `CDLE_FAST_HALF_CYC,
   parameter int SLOW_HALF  = `CDLE_SLOW_HALF_CYC,
   parameter int GAP        = `CDLE_GAP_CYC,
   parameter int FAST_COUNT = `CDLE_FAST_PULSES
) (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // I/O bus state
   input  wire logic       busRunning,
   input  wire logic       busError,
   input  wire logic [7:0] errCode,
   input  wire logic [7:0] errArg,
   input  wire logic       busBreak,
   input  wire logic [7:0] breakPos,
   input  wire logic       bootIpSwitchBad,
   // Ethernet state
   input  wire logic       rxActivity,
   input  wire logic       addrPending,
   input  wire logic       arpAddressed,
   input  wire logic       switchInvalid,
   input  wire logic       wdActive,
   input  wire logic       wdFault,
   // Lamps
   output logic            busOkLamp,
   output logic            busErrLamp,
   output logic            runLamp,
   output logic            comLamp,
   output logic            ethErrLamp,
   output logic            watchdog_lamp
);
   cdle_tick_if ticks();

   cdle_tick_gen #(
      .FAST_HALF (FAST_HALF),
      .SLOW_HALF (SLOW_HALF),
      .GAP       (GAP)
   ) u_ticks (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ticks   (ticks)
   );

   cdle_phase_t phase_q;
   logic [7:0]  code_q;
   logic [7:0]  arg_q;
   logic [8:0]  edges_q;
   logic        gap_q;
   logic        gapRun_q;
   logic        slowBlink_q;
   logic        fastBlink_q;
   logic [3:0]  arpEdges_q;
   logic        arpDone_q;
   logic        faultAny;
   logic [7:0]  selCode;
   logic [7:0]  selArg;
   logic        phaseEnd;

   // Switch faults take precedence, then bus breaks, then generic errors.
   always_comb begin
      faultAny = busError || busBreak || bootIpSwitchBad;
      if (bootIpSwitchBad) begin
         selCode = `CDLE_CODE_COUPLER;
         selArg  = `CDLE_ARG_BOOTIP;
      end else if (busBreak) begin
         selCode = `CDLE_CODE_BREAK;
         selArg  = breakPos;
      end else begin
         selCode = errCode;
         selArg  = errArg;
      end
   end

   // A phase of N pulses ends after 2N half periods of its own rate.
   always_comb begin
      case (phase_q)
         BLK_FAST: phaseEnd = ticks.fastTick &&
                              edges_q == 9'(2 * FAST_COUNT - 1);
         BLK_CODE: phaseEnd = ticks.slowTick &&
                              edges_q == {code_q, 1'b0} - 9'h1;
         BLK_ARG:  phaseEnd = ticks.slowTick &&
                              edges_q == {arg_q, 1'b0} - 9'h1;
         default:  phaseEnd = 1'b0;
      endcase
   end

   // Gaps separate phases; an empty train (count zero) is skipped as a gap.
   // The dividers also restart as a gap opens and as it closes, so each
   // gap lasts GAP + 1 cycles and each train opens with a whole dark half
   // period; a free-running divider would clip both by a random amount.
   assign ticks.restart = (phase_q == BLK_IDLE && !gap_q && faultAny) ||
                          (gap_q != gapRun_q);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         gapRun_q <= 1'b0;
      end else begin
         gapRun_q <= gap_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         phase_q <= BLK_IDLE;
         gap_q   <= 1'b0;
         code_q  <= 8'h00;
         arg_q   <= 8'h00;
      end else if (gap_q) begin
         if (ticks.gapTick) begin
            gap_q <= 1'b0;
         end
      end else begin
         case (phase_q)
            BLK_IDLE: begin
               if (faultAny) begin
                  code_q  <= selCode;
                  arg_q   <= selArg;
                  phase_q <= BLK_FAST;
               end
            end
            BLK_FAST: begin
               if (phaseEnd) begin
                  phase_q <= BLK_CODE;
                  gap_q   <= 1'b1;
               end
            end
            BLK_CODE: begin
               if (phaseEnd || code_q == 8'h00) begin
                  phase_q <= BLK_ARG;
                  gap_q   <= 1'b1;
               end
            end
            BLK_ARG: begin
               if (phaseEnd || arg_q == 8'h00) begin
                  phase_q <= BLK_IDLE;
                  gap_q   <= 1'b1;
               end
            end
            default: phase_q <= BLK_IDLE;
         endcase
      end
   end

   // Half-period edge counter within the current train.
   always_ff @(posedge clk_sys) begin
      if (rst || gap_q || phase_q == BLK_IDLE) begin
         edges_q <= 9'h000;
      end else if ((phase_q == BLK_FAST && ticks.fastTick) ||
                   (phase_q != BLK_FAST && ticks.slowTick)) begin
         edges_q <= edges_q + 9'h001;
      end
   end

   // Slow and fast square waves, re-phased on divider restarts; only the slow one drives an Ethernet lamp.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         slowBlink_q <= 1'b0;
      end else if (ticks.slowTick) begin
         slowBlink_q <= !slowBlink_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fastBlink_q <= 1'b0;
      end else if (ticks.fastTick) begin
         fastBlink_q <= !fastBlink_q;
      end
   end

   // ARP flashing is counted once after reset and never rearmed later.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         arpEdges_q <= 4'h0;
         arpDone_q  <= 1'b0;
      end else if (!arpDone_q) begin
         if (!arpAddressed && arpEdges_q == 4'h0) begin
            arpDone_q <= 1'b1;
         end else if (ticks.fastTick) begin
            if (arpEdges_q == 4'(2 * `CDLE_ARP_PULSES - 1)) begin
               arpDone_q <= 1'b1;
            end
            arpEdges_q <= arpEdges_q + 4'h1;
         end
      end
   end

   // Bus lamps.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         busOkLamp  <= 1'b0;
         busErrLamp <= 1'b0;
         runLamp    <= 1'b0;
      end else begin
         busOkLamp  <= busRunning && !faultAny;
         runLamp    <= busRunning;
         // Lit on odd half periods, so each pulse is one lit half.
         busErrLamp <= !gap_q && phase_q != BLK_IDLE &&
                       edges_q[0];
      end
   end

   // Ethernet lamps.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         comLamp       <= 1'b0;
         ethErrLamp    <= 1'b0;
         watchdog_lamp <= 1'b0;
      end else begin
         if (addrPending) begin
            comLamp <= slowBlink_q;
         end else begin
            comLamp <= rxActivity;
         end
         if (!arpDone_q && arpAddressed) begin
            ethErrLamp <= arpEdges_q[0];
         end else begin
            ethErrLamp <= switchInvalid;
         end
         watchdog_lamp <= wdActive && !wdFault;
      end
   end

   // Assertions.
   property p_ok;
      @(posedge clk_sys) disable iff (rst)
      busRunning && !faultAny |=> busOkLamp;
   endproperty
   a_ok: assert property (p_ok) else $error("green lamp not lit");

   property p_red;
      @(posedge clk_sys) disable iff (rst)
      phase_q == BLK_IDLE && !gap_q |=> !busErrLamp;
   endproperty
   a_red: assert property (p_red) else $error("red lit idle");

   property p_order;
      @(posedge clk_sys) disable iff (rst)
      phase_q == BLK_FAST && $changed(phase_q) |-> $past(phase_q) == BLK_IDLE;
   endproperty
   a_order: assert property (p_order) else $error("bad order");

   property p_brk;
      @(posedge clk_sys) disable iff (rst)
      phase_q == BLK_IDLE && !gap_q && busBreak && !bootIpSwitchBad
      |=> code_q == 8'h04 && arg_q == $past(breakPos);
   endproperty
   a_brk: assert property (p_brk) else $error("break code wrong");

   property p_boot;
      @(posedge clk_sys) disable iff (rst)
      phase_q == BLK_IDLE && !gap_q && bootIpSwitchBad
      |=> code_q == 8'h06 && arg_q == 8'h04;
   endproperty
   a_boot: assert property (p_boot) else $error("boot code wrong");

   property p_com;
      @(posedge clk_sys) disable iff (rst)
      !addrPending |=> comLamp == $past(rxActivity);
   endproperty
   a_com: assert property (p_com) else $error("com lamp wrong");

   property p_wd;
      @(posedge clk_sys) disable iff (rst)
      wdFault |=> !watchdog_lamp;
   endproperty
   a_wd: assert property (p_wd) else $error("watchdog lamp lit");

   property p_latch;
      @(posedge clk_sys) disable iff (rst)
      phase_q != BLK_IDLE && $past(phase_q) != BLK_IDLE
      |-> $stable(code_q) && $stable(arg_q);
   endproperty
   a_latch: assert property (p_latch) else $error("code changed");

   property p_run;
      @(posedge clk_sys) disable iff (rst)
      busRunning |=> runLamp;
   endproperty
   a_run: assert property (p_run) else $error("run lamp dark");

   property p_eth;
      @(posedge clk_sys) disable iff (rst)
      arpDone_q |=> ethErrLamp == $past(switchInvalid);
   endproperty
   a_eth: assert property (p_eth) else $error("error lamp wrong");

   property p_arp;
      @(posedge clk_sys) disable iff (rst)
      arpDone_q |=> arpDone_q && $stable(arpEdges_q);
   endproperty
   a_arp: assert property (p_arp) else $error("arp flash rearmed");
endmodule

/* File: hdl/cdle_pkg.sv */
package cdle_pkg;
   typedef enum logic [3:0] {
      BLK_IDLE  = 4'b0001,
      BLK_FAST  = 4'b0010,
      BLK_CODE  = 4'b0100,
      BLK_ARG   = 4'b1000
   } cdle_phase_t;
endpackage

/* File: hdl/cdle_tick_gen.sv */
`timescale 1ns/10ps
`include "cdle_consts.svh"
module cdle_tick_gen #(
   parameter int FAST_HALF = `CDLE_FAST_HALF_CYC,
   parameter int SLOW_HALF = `CDLE_SLOW_HALF_CYC,
   parameter int GAP       = `CDLE_GAP_CYC
) (
   // Clock and reset
   input wire logic    clk_sys,
   input wire logic    rst,
   // Tick carrier
   cdle_tick_if.gen    ticks
);
   logic [31:0] fastCnt_q;
   logic [31:0] slowCnt_q;
   logic [31:0] gapCnt_q;

   // Each divider restarts with the sequencer so phases start cleanly.
   always_ff @(posedge clk_sys) begin
      if (rst || ticks.restart || fastCnt_q == 32'(FAST_HALF - 1)) begin
         fastCnt_q <= 32'h0;
      end else begin
         fastCnt_q <= fastCnt_q + 32'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst || ticks.restart || slowCnt_q == 32'(SLOW_HALF - 1)) begin
         slowCnt_q <= 32'h0;
      end else begin
         slowCnt_q <= slowCnt_q + 32'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst || ticks.restart || gapCnt_q == 32'(GAP - 1)) begin
         gapCnt_q <= 32'h0;
      end else begin
         gapCnt_q <= gapCnt_q + 32'h1;
      end
   end

   assign ticks.fastTick = !ticks.restart && fastCnt_q == 32'(FAST_HALF - 1);
   assign ticks.slowTick = !ticks.restart && slowCnt_q == 32'(SLOW_HALF - 1);
   assign ticks.gapTick  = !ticks.restart && gapCnt_q == 32'(GAP - 1);
endmodule

/* File: hdl/cdle_tick_if.sv */
`timescale 1ns/10ps
interface cdle_tick_if;
   logic fastTick;
   logic slowTick;
   logic gapTick;
   logic restart;
   modport gen (output fastTick, output slowTick, output gapTick,
                input restart);
   modport use_ (input fastTick, input slowTick, input gapTick,
                 output restart);
endinterface
